// [core/apmc_map.svh]
// apmc_map.svh: offsets, field positions and reset values of the mask and control bank
// assumes: included by bare name from the package and the core modules
`ifndef APMC_MAP_SVH
`define APMC_MAP_SVH

// ----------------------------------------
// register offsets on the controller port
// ----------------------------------------
`define APMC_ADDR_STATUS_ONE 5'h00
`define APMC_ADDR_STATUS_TWO 5'h01
`define APMC_ADDR_STATUS_THREE 5'h02
`define APMC_ADDR_IDENT 5'h03
`define APMC_ADDR_CONTROL_ONE 5'h05
`define APMC_ADDR_CONTROL_TWO 5'h06
`define APMC_ADDR_MASK_ONE 5'h07
`define APMC_ADDR_MASK_TWO 5'h08
`define APMC_ADDR_MASK_THREE 5'h09

// ----------------------------------------
// reset values and used-bit masks
// ----------------------------------------
`define APMC_RST_CONTROL 8'h00
`define APMC_RST_MASK 8'h00
`define APMC_MASK_THREE_USED 8'h1F
`define APMC_CONTROL_TWO_USED 8'h03

// ----------------------------------------
// control one fields
// ----------------------------------------
`define APMC_C1_NO_HDR_CORRECT 0
`define APMC_C1_NO_HEC_GEN 1
`define APMC_C1_CELL_LOOP 2
`define APMC_C1_LINE_LOOP 3
`define APMC_C1_KEEP_MULTI_ERR 4
`define APMC_C1_KEEP_IDLE 5
`define APMC_C1_KEEP_UNASSIGNED 6
`define APMC_C1_STM1_FRAME 7

// ----------------------------------------
// control two fields
// ----------------------------------------
`define APMC_C2_RX_CLOCK_TO_TX 0
`define APMC_C2_UNASSIGNED_FILL 1

// ----------------------------------------
// cell header patterns
// ----------------------------------------
`define APMC_IDLE_HEADER 40'h0000000152
`define APMC_UNASSIGNED_HEADER 40'h0000000055

`endif

// [core/apmc_pkg.sv]
// apmc_pkg.sv: types shared by the mask and control bank
// assumes: apmc_map.svh on the include path
`include "apmc_map.svh"

package apmc_pkg;

    typedef logic [7:0] apmc_byte_t;
    typedef logic [4:0] apmc_addr_t;

    typedef enum logic [2:0] {
        APMC_CELL_PASS = 3'b001,
        APMC_CELL_DROP = 3'b010,
        APMC_CELL_NONE = 3'b100
    } apmc_verdict_e;

endpackage

// [core/apmc_sync2.sv]
// apmc_sync2.sv: two flip-flop level synchroniser for pin inputs
// assumes: a single clock; the first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none

module apmc_sync2 (
    // clock
    input wire logic i_clk,
    input wire logic i_ce,
    // level in and out
    input wire logic i_async,
    output logic o_sync
);

    logic meta_reg;

    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// [core/apmc_cell_filter.sv]
// apmc_cell_filter.sv: receive cell keep/drop verdict from header class and control bits
// assumes: header and error flag arrive on the same clock, one valid pulse per cell
`timescale 1ns/10ps
`default_nettype none
`include "apmc_map.svh"

module apmc_cell_filter
    import apmc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // policy bits
    input wire logic i_keep_multi_err,
    input wire logic i_keep_idle,
    input wire logic i_keep_unassigned,
    // cell header
    input wire logic i_hdr_valid,
    input wire logic [39:0] i_hdr,
    input wire logic i_hdr_multi_err,
    // verdict
    output apmc_verdict_e o_verdict
);

    function automatic logic is_hdr(input logic [39:0] h, input logic [39:0] pat);
        is_hdr = (h == pat);
    endfunction

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_verdict <= APMC_CELL_NONE;
        end else if (i_ce) begin
            if (!i_hdr_valid) begin
                o_verdict <= APMC_CELL_NONE;
            end else if (i_hdr_multi_err && !i_keep_multi_err) begin
                o_verdict <= APMC_CELL_DROP;
            end else if (is_hdr(i_hdr, `APMC_IDLE_HEADER) && !i_keep_idle) begin
                o_verdict <= APMC_CELL_DROP;
            end else if (is_hdr(i_hdr, `APMC_UNASSIGNED_HEADER) && !i_keep_unassigned) begin
                o_verdict <= APMC_CELL_DROP;
            end else begin
                o_verdict <= APMC_CELL_PASS;
            end
        end
    end

endmodule

`default_nettype wire

// [core/apmc_regs.sv]
// apmc_regs.sv: interrupt mask and control register bank of the line receiver/transmitter
// assumes: controller port is synchronous to i_clk; alarm status bits come from logic on i_clk
// Function
// - each status source can be masked individually by its mask bit
// - mask bit n gates status bit n of the same register number
// - any reset clears all three mask registers to zero
// - mask one at 07 maps parity, alignment, signal, frame and carrier losses
// - mask two at 08 maps AIS, FERF, data, pointer losses and block overflows
// - mask three at 09 maps violation overflows, RDI, FERF; top three unused
// - control registers at 05 and 06 clear on pin reset or ident write
// - control one bit 0 stops single-bit header correction
// - control one bit 1 suppresses transmit HEC generation
// - control one bit 2 loops transmit cells to receive, blocks serial input
// - cell loopback is register bit OR external pin
// - control one bit 3 loops receive serial data and clock to transmit
// - line loopback is register bit OR external pin
// - control one bit 4 disables dropping multiple-bit header error cells
// - bits 5, 6, 7 keep idle, keep unassigned, select STM-1 framing
// - control two bit 0 loops receive clock, bit 1 selects unassigned filler
// - with keep-multi set, errored cells go to the receive FIFO
// - header 00 00 00 01 52 counts as idle for the idle drop
// - STM-1 select is register bit OR external select input
`timescale 1ns/10ps
`default_nettype none
`include "apmc_map.svh"

module apmc_regs
    import apmc_pkg::*;
(
    // clock, enable, reset
    input wire logic i_clk,
    input wire logic i_ce,
    input wire logic i_rst_n,
    // controller port
    input wire logic i_cs,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [4:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // alarm status bits from the detectors
    input wire logic [7:0] i_status_one,
    input wire logic [7:0] i_status_two,
    input wire logic [7:0] i_status_three,
    input wire logic i_status_event,
    output logic o_interrupt_request_n,
    // external pins
    input wire logic i_cell_side_loopback,
    input wire logic i_line_side_loopback,
    input wire logic i_stm1_frame_select_in,
    input wire logic i_rx_clock_to_tx_in,
    // receive cell filter
    input wire logic i_hdr_valid,
    input wire logic [39:0] i_hdr,
    input wire logic i_hdr_multi_err,
    output apmc_verdict_e o_cell_verdict,
    // datapath controls
    output logic o_hdr_correct_en,
    output logic o_hec_gen_en,
    output logic o_cell_loop_en,
    output logic o_serial_in_block,
    output logic o_line_loop_en,
    output logic o_stm1_frame,
    output logic o_rx_clock_to_tx,
    output logic o_unassigned_fill,
    output logic o_soft_reset
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    apmc_byte_t control_one_reg;
    apmc_byte_t control_two_reg;
    apmc_byte_t alarm_mask_one_reg;
    apmc_byte_t alarm_mask_two_reg;
    apmc_byte_t alarm_mask_three_reg;
    logic bank_clear;
    logic wr_hit;
    logic rd_status;
    logic pin_cell_loop;
    logic pin_line_loop;
    logic pin_stm1;
    logic pin_clock_loop;
    logic gated_event;
    logic ident_hit;
    logic cell_loop_any;
    logic line_loop_any;
    logic stm1_any;
    logic clock_loop_any;
    apmc_byte_t rd_mux;

    function automatic logic addr_is(input apmc_addr_t a, input apmc_addr_t b);
        addr_is = (a == b);
    endfunction

    // true when any unmasked status bit is set
    function automatic logic mask_gate(input apmc_byte_t status, input apmc_byte_t mask);
        mask_gate = |(status & ~mask);
    endfunction

    // pins come from outside the clock domain
    apmc_sync2 u_sync_cell (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .i_async(i_cell_side_loopback),
        .o_sync(pin_cell_loop)
    );
    apmc_sync2 u_sync_line (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .i_async(i_line_side_loopback),
        .o_sync(pin_line_loop)
    );
    apmc_sync2 u_sync_stm1 (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .i_async(i_stm1_frame_select_in),
        .o_sync(pin_stm1)
    );
    apmc_sync2 u_sync_clk (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .i_async(i_rx_clock_to_tx_in),
        .o_sync(pin_clock_loop)
    );

    // ----------------------------------------
    // access decode
    // ----------------------------------------
    assign wr_hit = i_cs && i_wr;
    assign rd_status = i_cs && i_rd && (i_addr <= `APMC_ADDR_STATUS_THREE);
    assign ident_hit = wr_hit && addr_is(i_addr, `APMC_ADDR_IDENT);
    // a write to the ident register clears the mask, control and interrupt registers like the reset pin
    assign bank_clear = !i_rst_n || ident_hit;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_soft_reset <= 1'b0;
        end else if (i_ce) begin
            o_soft_reset <= ident_hit;
        end
    end

    // ----------------------------------------
    // mask registers
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (bank_clear) begin
            alarm_mask_one_reg <= `APMC_RST_MASK;
        end else if (i_ce && wr_hit && addr_is(i_addr, `APMC_ADDR_MASK_ONE)) begin
            alarm_mask_one_reg <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (bank_clear) begin
            alarm_mask_two_reg <= `APMC_RST_MASK;
        end else if (i_ce && wr_hit && addr_is(i_addr, `APMC_ADDR_MASK_TWO)) begin
            alarm_mask_two_reg <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (bank_clear) begin
            alarm_mask_three_reg <= `APMC_RST_MASK;
        end else if (i_ce && wr_hit && addr_is(i_addr, `APMC_ADDR_MASK_THREE)) begin
            alarm_mask_three_reg <= i_wdata & `APMC_MASK_THREE_USED;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (bank_clear) begin
            control_one_reg <= `APMC_RST_CONTROL;
        end else if (i_ce && wr_hit && addr_is(i_addr, `APMC_ADDR_CONTROL_ONE)) begin
            control_one_reg <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (bank_clear) begin
            control_two_reg <= `APMC_RST_CONTROL;
        end else if (i_ce && wr_hit && addr_is(i_addr, `APMC_ADDR_CONTROL_TWO)) begin
            control_two_reg <= i_wdata & `APMC_CONTROL_TWO_USED;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    // status one and two pass straight through, status three loses its top three bits; unmapped offsets read zero
    always_comb begin
        case (i_addr)
            `APMC_ADDR_STATUS_ONE: rd_mux = i_status_one;
            `APMC_ADDR_STATUS_TWO: rd_mux = i_status_two;
            `APMC_ADDR_STATUS_THREE: rd_mux = i_status_three & `APMC_MASK_THREE_USED;
            `APMC_ADDR_CONTROL_ONE: rd_mux = control_one_reg;
            `APMC_ADDR_CONTROL_TWO: rd_mux = control_two_reg;
            `APMC_ADDR_MASK_ONE: rd_mux = alarm_mask_one_reg;
            `APMC_ADDR_MASK_TWO: rd_mux = alarm_mask_two_reg;
            `APMC_ADDR_MASK_THREE: rd_mux = alarm_mask_three_reg;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_ce && i_cs && i_rd) begin
            o_rdata <= rd_mux;
        end
    end

    // ----------------------------------------
    // interrupt gating
    // ----------------------------------------
    // status bits are never touched here, masking only removes their pull on the pin
    assign gated_event = i_status_event && (
        mask_gate(i_status_one, alarm_mask_one_reg) ||
        mask_gate(i_status_two, alarm_mask_two_reg) ||
        mask_gate(i_status_three & `APMC_MASK_THREE_USED, alarm_mask_three_reg));

    // a new event in the cycle of a status read wins over the read
    always_ff @(posedge i_clk) begin
        if (bank_clear) begin
            o_interrupt_request_n <= 1'b1;
        end else if (i_ce) begin
            if (gated_event) begin
                o_interrupt_request_n <= 1'b0;
            end else if (rd_status) begin
                o_interrupt_request_n <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // pin OR terms
    // ----------------------------------------
    // the pin terms lag their pins by the two synchroniser stages
    assign cell_loop_any = control_one_reg[`APMC_C1_CELL_LOOP] || pin_cell_loop;
    assign line_loop_any = control_one_reg[`APMC_C1_LINE_LOOP] || pin_line_loop;
    assign stm1_any = control_one_reg[`APMC_C1_STM1_FRAME] || pin_stm1;
    assign clock_loop_any = control_two_reg[`APMC_C2_RX_CLOCK_TO_TX] || pin_clock_loop;

    // ----------------------------------------
    // datapath controls
    // ----------------------------------------
    // header check and HEC generation
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_hdr_correct_en <= 1'b1;
            o_hec_gen_en <= 1'b1;
        end else if (i_ce) begin
            o_hdr_correct_en <= !control_one_reg[`APMC_C1_NO_HDR_CORRECT];
            o_hec_gen_en <= !control_one_reg[`APMC_C1_NO_HEC_GEN];
        end
    end

    // loopbacks, framing and filler
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_cell_loop_en <= 1'b0;
            o_serial_in_block <= 1'b0;
            o_line_loop_en <= 1'b0;
            o_stm1_frame <= 1'b0;
            o_rx_clock_to_tx <= 1'b0;
            o_unassigned_fill <= 1'b0;
        end else if (i_ce) begin
            o_cell_loop_en <= cell_loop_any;
            o_serial_in_block <= cell_loop_any;
            o_line_loop_en <= line_loop_any;
            o_stm1_frame <= stm1_any;
            o_rx_clock_to_tx <= clock_loop_any;
            o_unassigned_fill <= control_two_reg[`APMC_C2_UNASSIGNED_FILL];
        end
    end

    // ----------------------------------------
    // receive cell drop policy
    // ----------------------------------------
    apmc_cell_filter u_filter (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_keep_multi_err(control_one_reg[`APMC_C1_KEEP_MULTI_ERR]),
        .i_keep_idle(control_one_reg[`APMC_C1_KEEP_IDLE]),
        .i_keep_unassigned(control_one_reg[`APMC_C1_KEEP_UNASSIGNED]),
        .i_hdr_valid(i_hdr_valid),
        .i_hdr(i_hdr),
        .i_hdr_multi_err(i_hdr_multi_err),
        .o_verdict(o_cell_verdict)
    );

endmodule

`default_nettype wire

// [bench/apmc_regs_sva.sv]
// apmc_regs_sva.sv: concurrent checks on the mask and control bank ports
// assumes: bound to apmc_regs, everything on i_clk
`timescale 1ns/10ps
`default_nettype none
module apmc_regs_sva
    import apmc_pkg::*;
(
    // clock and controller port
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_cs,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [4:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    // alarms, cells and controls
    input wire logic i_status_event,
    input wire logic o_interrupt_request_n,
    input wire logic i_hdr_valid,
    input wire apmc_verdict_e o_cell_verdict,
    input wire logic o_hdr_correct_en,
    input wire logic o_hec_gen_en,
    input wire logic o_cell_loop_en,
    input wire logic o_serial_in_block,
    input wire logic o_line_loop_en,
    input wire logic o_stm1_frame,
    input wire logic o_rx_clock_to_tx,
    input wire logic o_unassigned_fill,
    input wire logic o_soft_reset
);
    // ident write clears even with the clock enable low
    wire logic id_wr = i_cs && i_wr && i_addr == 5'h03;
    wire logic c1_wr = i_ce && i_cs && i_wr && i_addr == 5'h05;
    wire logic c2_wr = i_ce && i_cs && i_wr && i_addr == 5'h06;
    wire logic rd_irq = i_ce && i_cs && i_rd && i_addr <= 5'h02;
    wire logic rd_m3 = i_ce && i_cs && i_rd && i_addr == 5'h09;
    wire logic rd_void = i_ce && i_cs && i_rd && (i_addr == 5'h04 || i_addr >= 5'h0A);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    AST_CTL_RESET: assert property (disable iff (1'h0) !i_rst_n |=> o_hdr_correct_en && o_hec_gen_en
        && !o_unassigned_fill && !o_soft_reset && o_rdata == 8'h00 && o_cell_verdict == APMC_CELL_NONE)
        else $error("controls not cleared by reset");
    AST_C1_FIELDS: assert property (c1_wr ##1 !id_wr |=> o_hdr_correct_en == !$past(i_wdata[0], 2)
        && o_hec_gen_en == !$past(i_wdata[1], 2)) else $error("correction or hec enable wrong");
    AST_C1_LOOPS: assert property (c1_wr && i_wdata[2] ##1 !id_wr |=> o_cell_loop_en && o_serial_in_block)
        else $error("cell loopback not applied");
    AST_C1_LINE: assert property (c1_wr ##1 !id_wr |=> ($past(i_wdata[3], 2) -> o_line_loop_en)
        && ($past(i_wdata[7], 2) -> o_stm1_frame)) else $error("line loop or framing select wrong");
    AST_C2_FIELDS: assert property (c2_wr ##1 !id_wr |=> o_unassigned_fill == $past(i_wdata[1], 2)
        && ($past(i_wdata[0], 2) -> o_rx_clock_to_tx)) else $error("control two outputs wrong");
    AST_ID_CLEAR: assert property (id_wr |=> o_soft_reset ##[1:2] (o_hdr_correct_en && o_hec_gen_en
        && !o_unassigned_fill)) else $error("ident write did not clear");
    AST_MASK3_TOP: assert property (rd_m3 |=> o_rdata[7:5] == 3'h0) else $error("unused mask bits read set");
    AST_VOID_READ: assert property (rd_void |=> o_rdata == 8'h00) else $error("unmapped read not zero");
    AST_IRQ_CAUSE: assert property ($fell(o_interrupt_request_n) |-> $past(i_status_event))
        else $error("interrupt without status event");
    AST_IRQ_CLEAR: assert property (rd_irq && !i_status_event |=> o_interrupt_request_n)
        else $error("interrupt not released by status read");
    AST_VERDICT: assert property (i_ce && i_hdr_valid |=> o_cell_verdict inside {APMC_CELL_PASS, APMC_CELL_DROP})
        else $error("no verdict after header");
    cover property (c1_wr ##1 !id_wr);
    cover property (id_wr);
    cover property ($fell(o_interrupt_request_n));
endmodule
bind apmc_regs apmc_regs_sva i_sva (.i_clk, .i_rst_n, .i_ce, .i_cs, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata,
    .i_status_event, .o_interrupt_request_n, .i_hdr_valid, .o_cell_verdict, .o_hdr_correct_en, .o_hec_gen_en,
    .o_cell_loop_en, .o_serial_in_block, .o_line_loop_en, .o_stm1_frame, .o_rx_clock_to_tx, .o_unassigned_fill,
    .o_soft_reset);
`default_nettype wire

// [bench/apmc_host.sv]
// apmc_host.sv: host controller model driving the controller port
// assumes: one access at a time, launched 1 ns after a rising edge
`timescale 1ns/10ps
`default_nettype none
module apmc_host (
    // clock
    input wire logic i_clk,
    // controller port
    output logic o_cs,
    output logic o_wr,
    output logic o_rd,
    output logic [4:0] o_addr,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata
);
    initial begin
        o_cs = 1'h0;
        o_wr = 1'h0;
        o_rd = 1'h0;
        o_addr = 5'h1F;
        o_wdata = 8'hFF;
    end
    // released lines flip so a stale value can never pass for a driven one
    task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge i_clk);
        #1;
        o_cs = 1'h1;
        o_wr = w;
        o_rd = !w;
        o_addr = a;
        o_wdata = d;
        @(posedge i_clk);
        #1;
        q = i_rdata;
        o_cs = 1'h0;
        o_wr = 1'h0;
        o_rd = 1'h0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// [bench/apmc_regs_bench.sv]
// apmc_regs_bench.sv: self-checking bench for the mask and control bank
// assumes: apmc_host owns the controller port; clock enable held high except during the enable test
`timescale 1ns/10ps
`default_nettype none
module apmc_regs_bench;
    import apmc_pkg::*;
    typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] q;} apmc_row_s;
    typedef struct {logic [7:0] c; logic [39:0] h; logic m; apmc_verdict_e v;} apmc_cell_s;
    logic i_clk = 1'h0;
    logic i_rst_n = 1'h0;
    logic i_ce = 1'h1;
    logic i_cs, i_wr, i_rd, o_interrupt_request_n, o_soft_reset;
    logic [4:0] i_addr;
    logic [7:0] i_wdata, o_rdata, q, w, e, s;
    logic [7:0] i_status_one = 8'h00, i_status_two = 8'h00, i_status_three = 8'h00;
    logic i_status_event = 1'h0, i_hdr_valid = 1'h0, i_hdr_multi_err = 1'h0;
    logic [39:0] i_hdr = 40'h0;
    logic i_cell_side_loopback = 1'h0, i_line_side_loopback = 1'h0;
    logic i_stm1_frame_select_in = 1'h0, i_rx_clock_to_tx_in = 1'h0;
    logic o_hdr_correct_en, o_hec_gen_en, o_cell_loop_en, o_serial_in_block;
    logic o_line_loop_en, o_stm1_frame, o_rx_clock_to_tx, o_unassigned_fill;
    apmc_verdict_e o_cell_verdict;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    apmc_row_s rows [8] = '{'{5'h07, 8'h02, 8'h02}, '{5'h07, 8'hFF, 8'hFF}, '{5'h08, 8'hA5, 8'hA5},
        '{5'h09, 8'hFF, 8'h1F}, '{5'h05, 8'h5A, 8'h5A}, '{5'h06, 8'hFF, 8'h03}, '{5'h04, 8'hFF, 8'h00},
        '{5'h0A, 8'hFF, 8'h00}};
    apmc_cell_s cells [7] = '{'{8'h00, 40'h1234567890, 1'h1, APMC_CELL_DROP},
        '{8'h10, 40'h1234567890, 1'h1, APMC_CELL_PASS}, '{8'h00, 40'h0000000152, 1'h0, APMC_CELL_DROP},
        '{8'h20, 40'h0000000152, 1'h0, APMC_CELL_PASS}, '{8'h00, 40'h0000000055, 1'h0, APMC_CELL_DROP},
        '{8'h40, 40'h0000000055, 1'h0, APMC_CELL_PASS}, '{8'h00, 40'h1234567890, 1'h0, APMC_CELL_PASS}};
    always #10 i_clk = ~i_clk;
    apmc_host u_host (.i_clk, .o_cs(i_cs), .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata),
        .i_rdata(o_rdata));
    apmc_regs i_dut (.i_clk, .i_ce, .i_rst_n, .i_cs, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .i_status_one,
        .i_status_two, .i_status_three, .i_status_event, .o_interrupt_request_n, .i_cell_side_loopback,
        .i_line_side_loopback, .i_stm1_frame_select_in, .i_rx_clock_to_tx_in, .i_hdr_valid, .i_hdr,
        .i_hdr_multi_err, .o_cell_verdict, .o_hdr_correct_en, .o_hec_gen_en, .o_cell_loop_en, .o_serial_in_block,
        .o_line_loop_en, .o_stm1_frame, .o_rx_clock_to_tx, .o_unassigned_fill, .o_soft_reset);
    task automatic chk_byte(input string n, input logic [7:0] x, input logic [7:0] y);
        checked++;
        if (y !== x) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, x, y);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic chk_zero();
        for (int a = 5; a < 10; a++) begin
            u_host.access(1'h0, 5'(a), 8'h00, q);
            chk_byte("cleared", 8'h00, q);
        end
    endtask
    task automatic pulse_event(input logic [7:0] st);
        i_status_one = st;
        i_status_event = 1'h1;
        tick(1);
        i_status_event = 1'h0;
        tick(1);
    endtask
    task automatic summarize();
        $display("counts: checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // the whole run needs well under a thousand cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        tick(12);
        i_rst_n = 1'h1;
        foreach (rows[k]) begin
            u_host.access(1'h1, rows[k].a, rows[k].d, q);
            u_host.access(1'h0, rows[k].a, 8'h00, q);
            chk_byte("rdata", rows[k].q, q);
        end
        $display("test rows done");
        i_rst_n = 1'h0;
        tick(2);
        i_rst_n = 1'h1;
        chk_byte("enables", 8'h03, {6'h00, o_hdr_correct_en, o_hec_gen_en});
        chk_zero();
        $display("test reset done");
        for (int i = 0; i < 9; i++) begin
            w = (i == 8) ? 8'hFF : 8'(8'h01 << i);
            u_host.access(1'h1, 5'h05, w, q);
            tick(1);
            e = {2'h0, w[7], w[3], w[2], w[2], w[1], w[0]};
            s = {2'h0, o_stm1_frame, o_line_loop_en, o_cell_loop_en, o_serial_in_block, !o_hec_gen_en, !o_hdr_correct_en};
            chk_byte("controls", e, s);
        end
        $display("test controls done");
        u_host.access(1'h1, 5'h05, 8'h00, q);
        u_host.access(1'h1, 5'h06, 8'h02, q);
        {i_cell_side_loopback, i_line_side_loopback, i_stm1_frame_select_in, i_rx_clock_to_tx_in} = 4'hF;
        tick(4);
        s = {2'h0, o_serial_in_block, o_cell_loop_en,
            o_line_loop_en, o_stm1_frame, o_rx_clock_to_tx, o_unassigned_fill};
        chk_byte("pin or", 8'h3F, s);
        {i_cell_side_loopback, i_line_side_loopback, i_stm1_frame_select_in, i_rx_clock_to_tx_in} = 4'h0;
        $display("test pins done");
        foreach (cells[k]) begin
            u_host.access(1'h1, 5'h05, cells[k].c, q);
            tick(1);
            i_hdr_valid = 1'h1;
            i_hdr = cells[k].h;
            i_hdr_multi_err = cells[k].m;
            tick(1);
            i_hdr_valid = 1'h0;
            i_hdr = ~i_hdr;
            chk_byte("verdict", {5'h00, cells[k].v}, {5'h00, o_cell_verdict});
        end
        $display("test cells done");
        foreach (rows[k]) u_host.access(1'h1, rows[k].a, 8'hFF, q);
        u_host.access(1'h1, 5'h03, 8'h00, q);
        chk_byte("soft reset", 8'h01, {7'h00, o_soft_reset});
        tick(2);
        chk_zero();
        $display("test ident done");
        u_host.access(1'h1, 5'h07, 8'h02, q);
        pulse_event(8'h02);
        chk_byte("irq masked", 8'h01, {7'h00, o_interrupt_request_n});
        pulse_event(8'h03);
        chk_byte("irq raised", 8'h00, {7'h00, o_interrupt_request_n});
        u_host.access(1'h0, 5'h00, 8'h00, q);
        chk_byte("irq cleared", 8'h01, {7'h00, o_interrupt_request_n});
        $display("test interrupt done");
        i_ce = 1'h0;
        u_host.access(1'h1, 5'h07, 8'h55, q);
        i_ce = 1'h1;
        u_host.access(1'h0, 5'h07, 8'h00, q);
        chk_byte("frozen", 8'h02, q);
        $display("test enable done");
        summarize();
    end
endmodule
`default_nettype wire
